// ### logic/xau_pkg.sv
package xau_pkg;

    // Register port offsets
    localparam logic [1:0]  ADDR_ACC      = 2'h0;
    localparam logic [1:0]  ADDR_MQ       = 2'h1;
    localparam logic [1:0]  ADDR_FLAGS    = 2'h2;
    localparam logic [1:0]  ADDR_STEP     = 2'h3;

    // Flag register field positions
    localparam int          FLG_LINK      = 0;
    localparam int          FLG_GT        = 1;
    localparam int          FLG_MODE      = 2;
    localparam int          FLG_BUSY      = 3;

    // Reset values and compare constants
    localparam logic [11:0] WORD_RESET    = 12'h000;
    localparam logic [4:0]  SC_RESET      = 5'h00;
    localparam logic [4:0]  SC_LAST       = 5'h1f;
    localparam logic [4:0]  SC_PENULT     = 5'h1e;
    localparam logic [23:0] NORM_MIN_NEG  = 24'h800000;

    typedef enum logic [3:0] {
        OP_SHIFT_LEFT   = 4'h0,
        OP_ARITH_RIGHT  = 4'h1,
        OP_LOGIC_RIGHT  = 4'h2,
        OP_NORMALIZE    = 4'h3,
        OP_SKIP_ZERO    = 4'h4,
        OP_COMPLEMENT   = 4'h5,
        OP_INCREMENT    = 4'h6,
        OP_STORE        = 4'h7,
        OP_ADD          = 4'h8,
        OP_MODE_B       = 4'h9,
        OP_MODE_A       = 4'ha
    } xau_op_type;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_WAIT_CNT  = 3'b001,
        ST_SHIFT     = 3'b010,
        ST_NORM      = 3'b011,
        ST_PASS2     = 3'b100,
        ST_WAIT_EXEC = 3'b101,
        ST_EXEC      = 3'b110
    } xau_state_type;

endpackage : xau_pkg

// ### logic/xau_adder.sv
`timescale 1ns/1ps
module xau_adder
    import xau_pkg::*;
(
    input  wire logic [11:0] operand_a,
    input  wire logic [11:0] operand_b,
    input  wire logic        carry_in,
    output logic      [11:0] sum,
    output logic             carry_out
);
    logic [12:0] full_sum;

    assign full_sum  = {1'b0, operand_a} + {1'b0, operand_b} + {12'h000, carry_in};
    assign sum       = full_sum[11:0];
    assign carry_out = full_sum[12];
endmodule : xau_adder

// ### logic/xau_core.sv
// Overview of operation
// - Left shift: MQ top to AC, AC top to link
// - Each shift loads registers, counts, stops at 37
// - Mode A: last shift with extension released
// - Mode B: final step suppresses all shifting
// - Right shifts preset link at fetch pulse
// - Right shift feeds MQ bottom to GT in Mode B, clears GT in Mode A
// - Right shifts keep link, link feeds AC top
// - Normalize clears counter, holds extension line
// - Normalize shifts left while top bits equal
// - Normalize stops when AC2 to MQ11 zero
// - Mode B minimum negative stops, clears AC
// - Skip requested when 24 bits zero
// - Complement in two adder passes with carry
// - Second pass runs one unit step
// - Increment uses same passes without complement
// - Store and add force defer state
// - Second execute flag set, cleared after first
// - Store writes low, swaps, writes high, restores
// - Add clears link at fetch pulse
// - Add: memory plus MQ plus link into AC
// - One shift step per unit clock
// - Mode clears at reset, selects Mode A
// - Counter loads complement of low five bits
`timescale 1ns/1ps
module xau_core
    import xau_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    input  wire logic [3:0]  cmd_op,
    input  wire logic        operand_valid,
    input  wire logic [11:0] operand_word,
    input  wire logic        exec_enter,
    input  wire logic        exec_valid,
    input  wire logic [11:0] mem_word,
    input  wire logic [1:0]  reg_addr,
    input  wire logic [11:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [11:0] reg_rdata,
    output logic      [11:0] accumulator,
    output logic      [11:0] multiplier_quotient_reg,
    output logic             link,
    output logic             greater_than_flag,
    output logic             transfer_extension_line,
    output logic             skip_request,
    output logic             defer_request,
    output logic             second_execute_flag,
    output logic             accumulator_strobe,
    output logic             mulquot_strobe,
    output logic             greater_flag_strobe,
    output logic      [11:0] mem_write_data,
    output logic             mem_write_strobe,
    output logic             address_increment
);

    xau_state_type state_reg, state_next;
    xau_op_type    op_reg;
    logic [11:0]   ac_reg, mq_reg, wdata_reg, rdata_reg, add_a, add_b, add_sum;
    logic [4:0]    sc_reg;
    logic          link_reg, gt_reg, mode_b_reg, xfer_reg, skip_reg, defer_reg, ex2_reg, wr_reg, inc_reg;
    logic          ac_stb_reg, mq_stb_reg, gt_stb_reg;
    logic          add_cin, add_cout, shift_ok, is_right, norm_stop, cmd_take;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    assign cmd_take  = (state_reg == ST_IDLE) && cmd_valid;
    assign is_right  = (op_reg == OP_ARITH_RIGHT) || (op_reg == OP_LOGIC_RIGHT);
    // Mode B withholds the permit on the final count, so no extra shift
    assign shift_ok  = !(mode_b_reg && (sc_reg == SC_LAST));
    // Unnormalizable: AC2 down through MQ11 all zero
    assign norm_stop = (ac_reg[11] != ac_reg[10]) || ({ac_reg[9:0], mq_reg} == 22'h000000);

    always_comb begin
        add_a   = WORD_RESET;
        add_b   = WORD_RESET;
        add_cin = 1'b0;
        if (state_reg == ST_PASS2) begin
            // Pass 1 parked the high word in MQ, so pass 2 works on MQ
            add_a   = (op_reg == OP_COMPLEMENT) ? ~mq_reg : mq_reg;
            add_cin = link_reg;
        end else if (state_reg == ST_EXEC) begin
            add_a   = mem_word;
            add_b   = mq_reg;
            add_cin = link_reg;
        end else begin
            add_a   = (cmd_op == OP_COMPLEMENT) ? ~mq_reg : mq_reg;
            add_cin = 1'b1;
        end
    end

    xau_adder u_adder (
        .operand_a (add_a),
        .operand_b (add_b),
        .carry_in  (add_cin),
        .sum       (add_sum),
        .carry_out (add_cout)
    );
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cmd_valid) begin
                    case (cmd_op)
                        OP_SHIFT_LEFT, OP_ARITH_RIGHT, OP_LOGIC_RIGHT: state_next = ST_WAIT_CNT;
                        OP_NORMALIZE:                 state_next = ST_NORM;
                        OP_COMPLEMENT, OP_INCREMENT:  state_next = ST_PASS2;
                        OP_STORE, OP_ADD:             state_next = ST_WAIT_EXEC;
                        default:                      state_next = ST_IDLE;
                    endcase
                end
            end
            ST_WAIT_CNT:  if (operand_valid) state_next = ST_SHIFT;
            ST_SHIFT:     if (sc_reg == SC_LAST) state_next = ST_IDLE;
            ST_NORM:      if (norm_stop) state_next = ST_IDLE;
            ST_PASS2:     state_next = ST_IDLE;
            ST_WAIT_EXEC: if (exec_enter) state_next = ST_EXEC;
            ST_EXEC:      if (exec_valid && !ex2_reg) state_next = ST_IDLE;
            default:      state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            op_reg    <= OP_SHIFT_LEFT;
        end else begin
            state_reg <= state_next;
            if (cmd_take) begin
                op_reg <= xau_op_type'(cmd_op);
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_b_reg <= 1'b0;
        end else if (cmd_take && (cmd_op == OP_MODE_B)) begin
            mode_b_reg <= 1'b1;
        end else if (cmd_take && (cmd_op == OP_MODE_A)) begin
            mode_b_reg <= 1'b0;
        end else if (reg_wr && (state_reg == ST_IDLE) && (reg_addr == ADDR_FLAGS)) begin
            mode_b_reg <= reg_wdata[FLG_MODE];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sc_reg <= SC_RESET;
        end else if (cmd_take && (cmd_op == OP_NORMALIZE)) begin
            sc_reg <= SC_RESET;
        end else if ((state_reg == ST_WAIT_CNT) && operand_valid) begin
            sc_reg <= ~operand_word[4:0];
        end else if ((state_reg == ST_SHIFT) || ((state_reg == ST_NORM) && !norm_stop)) begin
            sc_reg <= sc_reg + 5'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ac_reg     <= WORD_RESET;
            mq_reg     <= WORD_RESET;
            link_reg   <= 1'b0;
            gt_reg     <= 1'b0;
            ac_stb_reg <= 1'b0;
            mq_stb_reg <= 1'b0;
            gt_stb_reg <= 1'b0;
        end else begin
            ac_stb_reg <= 1'b0;
            mq_stb_reg <= 1'b0;
            gt_stb_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        case (cmd_op)
                            OP_ARITH_RIGHT: link_reg <= ac_reg[11];
                            OP_LOGIC_RIGHT: link_reg <= 1'b0;
                            OP_ADD:         link_reg <= 1'b0;
                            OP_COMPLEMENT, OP_INCREMENT: begin
                                // Processor swap path moves AC to MQ in this pass
                                ac_reg     <= add_sum;
                                mq_reg     <= ac_reg;
                                link_reg   <= add_cout;
                                ac_stb_reg <= 1'b1;
                                mq_stb_reg <= 1'b1;
                            end
                            default: ;
                        endcase
                    end else if (reg_wr) begin
                        if (reg_addr == ADDR_ACC) begin
                            ac_reg <= reg_wdata;
                        end else if (reg_addr == ADDR_MQ) begin
                            mq_reg <= reg_wdata;
                        end else if (reg_addr == ADDR_FLAGS) begin
                            link_reg <= reg_wdata[FLG_LINK];
                            gt_reg   <= reg_wdata[FLG_GT];
                        end
                    end
                end
                ST_SHIFT: begin
                    if (shift_ok) begin
                        ac_stb_reg <= 1'b1;
                        mq_stb_reg <= 1'b1;
                        if (is_right) begin
                            // Link is not loaded; its output feeds the AC top
                            ac_reg     <= {link_reg, ac_reg[11:1]};
                            mq_reg     <= {ac_reg[0], mq_reg[11:1]};
                            gt_reg     <= mode_b_reg & mq_reg[0];
                            gt_stb_reg <= 1'b1;
                        end else begin
                            ac_reg   <= {ac_reg[10:0], mq_reg[11]};
                            link_reg <= ac_reg[11];
                            mq_reg   <= {mq_reg[10:0], 1'b0};
                        end
                    end
                end
                ST_NORM: begin
                    if (!norm_stop) begin
                        ac_reg     <= {ac_reg[10:0], mq_reg[11]};
                        link_reg   <= ac_reg[11];
                        mq_reg     <= {mq_reg[10:0], 1'b0};
                        ac_stb_reg <= 1'b1;
                        mq_stb_reg <= 1'b1;
                    end else if (mode_b_reg && ({ac_reg, mq_reg} == NORM_MIN_NEG)) begin
                        ac_reg     <= WORD_RESET;
                        ac_stb_reg <= 1'b1;
                    end
                end
                ST_PASS2: begin
                    ac_reg     <= add_sum;
                    mq_reg     <= ac_reg;
                    link_reg   <= add_cout;
                    ac_stb_reg <= 1'b1;
                    mq_stb_reg <= 1'b1;
                end
                ST_EXEC: begin
                    if (exec_valid) begin
                        ac_stb_reg <= 1'b1;
                        mq_stb_reg <= 1'b1;
                        mq_reg     <= ac_reg;
                        if (op_reg == OP_ADD) begin
                            ac_reg   <= add_sum;
                            link_reg <= add_cout;
                        end else begin
                            ac_reg <= mq_reg;
                        end
                    end
                end
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            xfer_reg  <= 1'b0;
            skip_reg  <= 1'b0;
            defer_reg <= 1'b0;
            ex2_reg   <= 1'b0;
            wdata_reg <= WORD_RESET;
            wr_reg    <= 1'b0;
            inc_reg   <= 1'b0;
        end else begin
            skip_reg  <= 1'b0;
            defer_reg <= 1'b0;
            wr_reg    <= 1'b0;
            inc_reg   <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        skip_reg  <= (cmd_op == OP_SKIP_ZERO) && ({ac_reg, mq_reg} == 24'h000000);
                        defer_reg <= (cmd_op == OP_STORE) || (cmd_op == OP_ADD);
                        xfer_reg  <= (cmd_op == OP_NORMALIZE) || (cmd_op == OP_COMPLEMENT)
                                     || (cmd_op == OP_INCREMENT);
                    end
                end
                // Released one step early so the last Mode A shift runs with it low
                ST_WAIT_CNT: if (operand_valid) xfer_reg <= (~operand_word[4:0] != SC_LAST);
                ST_SHIFT:    xfer_reg <= (sc_reg != SC_PENULT) && (sc_reg != SC_LAST);
                ST_NORM:     if (norm_stop) xfer_reg <= 1'b0;
                ST_PASS2:    xfer_reg <= 1'b0;
                ST_WAIT_EXEC: if (exec_enter) ex2_reg <= 1'b1;
                ST_EXEC: begin
                    if (exec_valid) begin
                        ex2_reg <= 1'b0;
                        inc_reg <= ex2_reg;
                        if (op_reg == OP_STORE) begin
                            wdata_reg <= mq_reg;
                            wr_reg    <= 1'b1;
                        end
                    end
                end
                default: xfer_reg <= 1'b0;
            endcase
        end
    end

    // Read data stand one cycle only, zero otherwise
    always_ff @(posedge clk) begin
        if (!rst_n || !reg_rd) begin
            rdata_reg <= WORD_RESET;
        end else if (reg_addr == ADDR_ACC) begin
            rdata_reg <= ac_reg;
        end else if (reg_addr == ADDR_MQ) begin
            rdata_reg <= mq_reg;
        end else if (reg_addr == ADDR_FLAGS) begin
            rdata_reg <= {8'h00, (state_reg != ST_IDLE), mode_b_reg, gt_reg, link_reg};
        end else begin
            rdata_reg <= {7'h00, sc_reg};
        end
    end

    assign reg_rdata               = rdata_reg;
    assign accumulator             = ac_reg;
    assign multiplier_quotient_reg = mq_reg;
    assign link                    = link_reg;
    assign greater_than_flag       = gt_reg;
    assign transfer_extension_line = xfer_reg;
    assign skip_request            = skip_reg;
    assign defer_request           = defer_reg;
    assign second_execute_flag     = ex2_reg;
    assign accumulator_strobe      = ac_stb_reg;
    assign mulquot_strobe          = mq_stb_reg;
    assign greater_flag_strobe     = gt_stb_reg;
    assign mem_write_data          = wdata_reg;
    assign mem_write_strobe        = wr_reg;
    assign address_increment       = inc_reg;

    property p_left_path;
        (state_reg == ST_SHIFT) && shift_ok && !is_right
        |=> (ac_reg[0] == $past(mq_reg[11])) && (link_reg == $past(ac_reg[11])) && !mq_reg[0];
    endproperty
    a_left_path: assert property (p_left_path) else $error("left shift path wrong");
    property p_step_count;
        (state_reg == ST_SHIFT) && shift_ok |=> ac_stb_reg && mq_stb_reg && (sc_reg == $past(sc_reg) + 5'h01);
    endproperty
    a_step_count: assert property (p_step_count) else $error("shift step missing load or count");
    property p_mode_b_final;
        (state_reg == ST_SHIFT) && mode_b_reg && (sc_reg == SC_LAST)
        |=> !ac_stb_reg && $stable(ac_reg) && $stable(mq_reg) && (state_reg == ST_IDLE);
    endproperty
    a_mode_b_final: assert property (p_mode_b_final) else $error("mode b final step shifted");
    property p_logical_link;
        cmd_take && (cmd_op == OP_LOGIC_RIGHT) |=> !link_reg ##1 (state_reg == ST_WAIT_CNT);
    endproperty
    a_logical_link: assert property (p_logical_link) else $error("link not cleared for right shift");
    property p_right_gt;
        (state_reg == ST_SHIFT) && shift_ok && is_right
        |=> gt_stb_reg && (gt_reg == ($past(mode_b_reg) & $past(mq_reg[0])));
    endproperty
    a_right_gt: assert property (p_right_gt) else $error("gt flag not fed from mq");
    property p_right_link;
        (state_reg == ST_SHIFT) && shift_ok && is_right |=> $stable(link_reg) && (ac_reg[11] == link_reg);
    endproperty
    a_right_link: assert property (p_right_link) else $error("link disturbed in right shift");
    property p_skip_zero;
        cmd_take && (cmd_op == OP_SKIP_ZERO) |=> (skip_reg == ($past({ac_reg, mq_reg}) == 24'h000000)) ##1 !skip_reg;
    endproperty
    a_skip_zero: assert property (p_skip_zero) else $error("skip request wrong");
    property p_second_exec;
        (state_reg == ST_EXEC) && exec_valid && ex2_reg |=> !ex2_reg && address_increment && (state_reg == ST_EXEC);
    endproperty
    a_second_exec: assert property (p_second_exec) else $error("second execute not forced");
    property p_norm_min;
        (state_reg == ST_NORM) && mode_b_reg && ({ac_reg, mq_reg} == NORM_MIN_NEG)
        |=> (ac_reg == WORD_RESET) && !transfer_extension_line;
    endproperty
    a_norm_min: assert property (p_norm_min) else $error("minimum negative not cleared");

endmodule : xau_core

// ### verif/xau_host_model.sv
`timescale 1ns/1ps
module xau_host_model
    import xau_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    input  wire logic [3:0]  cmd_op,
    input  wire logic        defer_request,
    input  wire logic        address_increment,
    input  wire logic [11:0] count_word,
    input  wire logic [11:0] mem_lo,
    input  wire logic [11:0] mem_hi,
    input  wire logic [1:0]  gap,
    output logic             operand_valid,
    output logic      [11:0] operand_word,
    output logic             exec_enter,
    output logic             exec_valid,
    output logic      [11:0] mem_word
);
    logic hi_reg;

    // Second execute cycle fetches from the advanced address
    always @(posedge clk) begin
        if (!rst_n || exec_enter) hi_reg <= 1'b0;
        else if (address_increment) hi_reg <= 1'b1;
    end

    task automatic pause;
        repeat (int'(gap) + 1) @(posedge clk);
    endtask : pause

    // Undriven words show the inverse so a stale value never looks valid
    initial begin
        operand_valid = 1'b0;
        exec_enter    = 1'b0;
        exec_valid    = 1'b0;
        operand_word  = 12'h000;
        mem_word      = 12'h000;
        forever begin
            @(posedge clk);
            if (rst_n && cmd_valid && cmd_op <= OP_LOGIC_RIGHT) begin
                pause;
                operand_valid <= 1'b1;
                operand_word  <= count_word;
                @(posedge clk);
                operand_valid <= 1'b0;
                operand_word  <= ~count_word;
            end
            if (rst_n && defer_request) begin
                pause;
                exec_enter <= 1'b1;
                @(posedge clk);
                exec_enter <= 1'b0;
                repeat (2) begin
                    pause;
                    exec_valid <= 1'b1;
                    mem_word   <= (hi_reg || address_increment) ? mem_hi : mem_lo;
                    @(posedge clk);
                    exec_valid <= 1'b0;
                    mem_word   <= ~mem_word;
                end
            end
        end
    end
endmodule : xau_host_model

// ### verif/extended_arith_shift_double_ops_tb.sv
`timescale 1ns/1ps
module extended_arith_shift_double_ops_tb;
    import xau_pkg::*;
    logic        clk, rst_n, cmd_valid, operand_valid, exec_enter, exec_valid, reg_wr, reg_rd, link;
    logic        greater_than_flag, transfer_extension_line, skip_request, defer_request, second_execute_flag;
    logic        accumulator_strobe, mulquot_strobe, greater_flag_strobe, mem_write_strobe, address_increment;
    logic [3:0]  cmd_op;
    logic [1:0]  reg_addr, gap;
    logic [11:0] operand_word, mem_word, reg_wdata, reg_rdata, accumulator, multiplier_quotient_reg;
    logic [11:0] mem_write_data, count_word, w0, w1;
    logic [11:0] wq[$];
    int          n_fail, checked;
    int          cnt[5];

    xau_core uut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .operand_valid(operand_valid),
        .operand_word(operand_word), .exec_enter(exec_enter), .exec_valid(exec_valid), .mem_word(mem_word),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .accumulator(accumulator), .multiplier_quotient_reg(multiplier_quotient_reg), .link(link),
        .greater_than_flag(greater_than_flag), .transfer_extension_line(transfer_extension_line),
        .skip_request(skip_request), .defer_request(defer_request), .second_execute_flag(second_execute_flag),
        .accumulator_strobe(accumulator_strobe), .mulquot_strobe(mulquot_strobe),
        .greater_flag_strobe(greater_flag_strobe), .mem_write_data(mem_write_data),
        .mem_write_strobe(mem_write_strobe), .address_increment(address_increment));

    xau_host_model host (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .defer_request(defer_request), .address_increment(address_increment), .count_word(count_word),
        .mem_lo(w0), .mem_hi(w1), .gap(gap), .operand_valid(operand_valid), .operand_word(operand_word),
        .exec_enter(exec_enter), .exec_valid(exec_valid), .mem_word(mem_word));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cnt[0] += int'(skip_request);
        cnt[1] += int'(defer_request);
        cnt[2] += int'(address_increment);
        cnt[3] += int'(accumulator_strobe);
        cnt[4] += int'(second_execute_flag);
        if (mem_write_strobe) wq.push_back(mem_write_data);
    end

    // Returns {shift count, gt, link, acc, mq}
    function automatic logic [31:0] model(input logic [3:0] op, input logic mb, input logic [11:0] a, m,
                                          input logic l, input logic [4:0] n);
        logic [24:0] v;
        logic [12:0] lo, hi;
        logic        g;
        int          c, k;
        v = {l, a, m};
        g = 1'b0;
        c = 0;
        k = mb ? int'(n) : int'(n) + 1;
        case (op)
            OP_SHIFT_LEFT: begin
                c = k;
                repeat (k) v = {v[23:0], 1'b0};
            end
            OP_ARITH_RIGHT, OP_LOGIC_RIGHT: begin
                c = k;
                v[24] = (op == OP_ARITH_RIGHT) & a[11];
                repeat (k) begin
                    g = v[0] & mb;
                    v = {v[24], v[24:1]};
                end
            end
            OP_NORMALIZE: begin
                while (v[23] == v[22] && v[21:0] != 22'h0) begin
                    v = {v[23:0], 1'b0};
                    c++;
                end
                if (mb && v[23:0] == NORM_MIN_NEG) v[23:12] = 12'h000;
            end
            OP_COMPLEMENT, OP_INCREMENT: begin
                lo = (op == OP_COMPLEMENT ? {1'b0, ~m} : {1'b0, m}) + 13'h001;
                hi = (op == OP_COMPLEMENT ? {1'b0, ~a} : {1'b0, a}) + 13'(lo[12]);
                v  = {hi, lo[11:0]};
            end
            OP_ADD: begin
                lo = m + w0;
                hi = a + w1 + 13'(lo[12]);
                v  = {hi, lo[11:0]};
            end
            default: v = {l, a, m};
        endcase
        return {6'(c), g, v};
    endfunction : model

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (!ok) begin
            n_fail++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out

    task automatic wr(input logic [1:0] a, input logic [11:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [11:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic issue(input logic [3:0] op);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op    <= op;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : issue

    task automatic wait_idle(output logic [11:0] f);
        int t;
        t = 0;
        f = 12'hfff;
        while (f[FLG_BUSY] !== 1'b0) begin
            rd(ADDR_FLAGS, f);
            t++;
            if (t > 300) begin
                chk(1'b0, "timeout waiting for idle");
                close_out;
            end
        end
    endtask : wait_idle

    task automatic run(input logic [3:0] op, input logic mb, input logic [11:0] a, m, input logic l,
                       input logic [4:0] n);
        logic [31:0] e;
        logic [11:0] f;
        int          c0[5];
        e = model(op, mb, a, m, l, n);
        wr(ADDR_ACC, a);
        wr(ADDR_MQ, m);
        wr(ADDR_FLAGS, {9'h000, mb, 1'b0, l});
        count_word <= {7'($urandom), n};
        #1 c0 = cnt;
        wq.delete();
        issue(op);
        wait_idle(f);
        chk({link, accumulator, multiplier_quotient_reg} === e[24:0], "datapath result");
        chk(greater_than_flag === e[25] && f[2:0] === {mb, e[25:24]}, "flag result");
        if (op <= OP_LOGIC_RIGHT) chk(cnt[3] - c0[3] == int'(e[31:26]), "shift strobe count");
        if (op == OP_NORMALIZE) rd(ADDR_STEP, f);
        if (op == OP_NORMALIZE) chk(f === 12'(e[31:26]), "normalize count");
        chk(cnt[0] - c0[0] == int'(op == OP_SKIP_ZERO && {a, m} == 24'h0), "skip pulse");
        if (op == OP_STORE || op == OP_ADD)
            chk(cnt[1] - c0[1] == 1 && cnt[2] - c0[2] == 1 && cnt[4] > c0[4], "execute pair");
        if (op == OP_STORE) chk(wq.size() == 2 && wq[0] === m && wq[1] === a, "stored words");
        $display("Test op %0d mode %0d done", op, mb);
    endtask : run

    initial begin
        logic [11:0] f;
        {rst_n, cmd_valid, reg_wr, reg_rd, cmd_op, reg_addr, gap} = '0;
        {reg_wdata, count_word, w0, w1} = '0;
        n_fail  = 0;
        checked = 0;
        void'($urandom(3));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_FLAGS, f);
        chk(f === 12'h000 && accumulator === 12'h000, "reset state");
        wr(ADDR_STEP, 12'h015);
        rd(ADDR_STEP, f);
        chk(f === 12'h000, "step counter read only");
        issue(OP_MODE_B);
        wait_idle(f);
        chk(f[FLG_MODE] === 1'b1, "mode b select");
        issue(OP_MODE_A);
        wait_idle(f);
        chk(f[FLG_MODE] === 1'b0, "mode a select");
        $display("Test reset and mode done");
        run(OP_COMPLEMENT, 1'b0, 12'h000, 12'h000, 1'b0, 5'h00);
        run(OP_INCREMENT, 1'b1, 12'hfff, 12'hfff, 1'b0, 5'h00);
        run(OP_SKIP_ZERO, 1'b0, 12'h000, 12'h000, 1'b1, 5'h00);
        run(OP_NORMALIZE, 1'b1, 12'h800, 12'h000, 1'b0, 5'h00);
        run(OP_NORMALIZE, 1'b0, 12'h000, 12'h001, 1'b1, 5'h00);
        run(OP_NORMALIZE, 1'b1, 12'hc00, 12'h000, 1'b0, 5'h00);
        run(OP_SHIFT_LEFT, 1'b0, 12'h801, 12'h800, 1'b1, 5'h1f);
        run(OP_ARITH_RIGHT, 1'b1, 12'h800, 12'h003, 1'b0, 5'h00);
        run(OP_LOGIC_RIGHT, 1'b1, 12'h800, 12'h003, 1'b1, 5'h02);
        w0 = 12'hfff;
        w1 = 12'hfff;
        run(OP_ADD, 1'b0, 12'hfff, 12'hfff, 1'b1, 5'h00);
        run(OP_STORE, 1'b1, 12'h5a3, 12'h0c7, 1'b1, 5'h00);
        repeat (40) begin
            w0  = 12'($urandom);
            w1  = 12'($urandom);
            gap <= 2'($urandom);
            run(4'($urandom_range(8, 0)), 1'($urandom), 12'($urandom), 12'($urandom), 1'($urandom), 5'($urandom));
        end
        close_out;
    end
endmodule : extended_arith_shift_double_ops_tb
